// File: rtl/i2sf_map.vh
// register offsets, field positions, reset values and mode codes of the i2c status block
// assumes a byte-wide register port and one 250 MHz system clock
`ifndef I2SF_MAP_VH
`define I2SF_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define I2SF_OFS_STATUS 8'h00
`define I2SF_OFS_CTRL 8'h01
`define I2SF_OFS_CTRL2 8'h02
`define I2SF_OFS_SLV_ADDR 8'h03
`define I2SF_OFS_BUFFER 8'h04
`define I2SF_OFS_IRQ_STAT 8'h05
`define I2SF_OFS_IRQ_MASK 8'h06

// ****************************************
// status field positions
// ****************************************
`define I2SF_ST_SLEW 7
`define I2SF_ST_SMBUS 6
`define I2SF_ST_DATA_ADDR 5
`define I2SF_ST_STOP 4
`define I2SF_ST_START 3
`define I2SF_ST_RW 2
`define I2SF_ST_UA 1
`define I2SF_ST_BF 0

// ****************************************
// control fields
// ****************************************
`define I2SF_CT_ENABLE 5
`define I2SF_CT_MODE_HI 3
`define I2SF_CT_MODE_LO 0
`define I2SF_C2_MASTER_BITS 5
`define I2SF_IRQ_BITS 4
`define I2SF_IRQ_BYTE 0
`define I2SF_IRQ_START 1
`define I2SF_IRQ_STOP 2
`define I2SF_IRQ_UA 3

// ****************************************
// mode codes and reset values
// ****************************************
`define I2SF_MODE_SLV10_INT 4'hf
`define I2SF_MODE_SLV7_INT 4'he
`define I2SF_MODE_MST_FW 4'hb
`define I2SF_MODE_MST 4'h8
`define I2SF_MODE_SLV10 4'h7
`define I2SF_MODE_SLV7 4'h6
`define I2SF_RST_BYTE 8'h00
`define I2SF_ACK_BIT 4'h8
`define I2SF_LAST_DATA_BIT 4'h7

`endif

// File: rtl/i2sf_sync.v
// two flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to sys_clk; first stage read only by the second
`timescale 1ns/10ps
`default_nettype none

module i2sf_sync #(
  parameter WIDTH = 2
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // two stages, pins idle high
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // i2sf_sync

`default_nettype wire

// File: rtl/i2sf_cond_det.v
// start, stop and clock edge detection on synchronised bus lines
// assumes scl and sda already passed a synchroniser on sys_clk
`timescale 1ns/10ps
`default_nettype none

module i2sf_cond_det (
  input wire sys_clk,
  input wire rst_b,
  input wire scl,
  input wire sda,
  output wire start_det,
  output wire stop_det,
  output wire scl_rise
);

  reg scl_d_r;
  reg sda_d_r;

  // previous line levels
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // sda falling with scl high is start, rising is stop
  assign start_det = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_det = scl & scl_d_r & ~sda_d_r & sda;
  assign scl_rise = scl & ~scl_d_r;

endmodule // i2sf_cond_det

`default_nettype wire

// File: rtl/i2sf_status_top.v
// status flag logic of an i2c serial port, master or slave
// assumes a byte register port on sys_clk and open-drain bus lines observed through pins
//
// Functional notes
// RULE_01: slave mode data/address flag is 1 after data byte, 0 after address.
// RULE_02: stop flag set when last bus condition was stop, else 0.
// RULE_03: master mode direction bit shows transmit in progress.
// RULE_04: 10-bit slave raises address update; writing slave address clears it.
// RULE_05: buffer full flag tracks held byte, excluding ack and stop bits.
// RULE_06: start flag set on start or repeated start, cleared by later stop.
// RULE_07: slave direction bit holds address r/w until start, stop or nack.
// RULE_08: master active when transmit busy or any master enable bit set.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "i2sf_map.vh"

module i2sf_status_top (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire scl_in,
  input wire sda_in,
  output wire irq,
  output wire master_active
);

  // ****************************************
  // decode helpers
  // ****************************************

  // register offset hit
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // mode classes
  function is_master;
    input [3:0] mode;
    begin
      is_master = (mode == `I2SF_MODE_MST) || (mode == `I2SF_MODE_MST_FW);
    end
  endfunction

  function is_slave;
    input [3:0] mode;
    begin
      is_slave = (mode == `I2SF_MODE_SLV7) || (mode == `I2SF_MODE_SLV10) ||
                 (mode == `I2SF_MODE_SLV7_INT) || (mode == `I2SF_MODE_SLV10_INT);
    end
  endfunction

  function is_ten;
    input [3:0] mode;
    begin
      is_ten = (mode == `I2SF_MODE_SLV10) || (mode == `I2SF_MODE_SLV10_INT);
    end
  endfunction

  // ****************************************
  // bus line sampling
  // ****************************************
  wire [1:0] line_sync;
  wire scl_s;
  wire sda_s;
  wire start_det;
  wire stop_det;
  wire scl_rise;

  i2sf_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in}),
    .sync_out(line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  i2sf_cond_det u_det (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .scl(scl_s),
    .sda(sda_s),
    .start_det(start_det),
    .stop_det(stop_det),
    .scl_rise(scl_rise)
  );

  // ****************************************
  // state registers
  // ****************************************
  reg [7:0] rdata_r;
  reg irq_r;
  reg active_r;
  reg slew_r;
  reg smbus_r;
  reg enable_r;
  reg [3:0] mode_r;
  reg [`I2SF_C2_MASTER_BITS-1:0] ctl2_r;
  reg [7:0] slv_addr_r;
  reg [7:0] buffer_r;
  reg [`I2SF_IRQ_BITS-1:0] irq_stat_r;
  reg [`I2SF_IRQ_BITS-1:0] irq_mask_r;
  reg data_addr_r;
  reg stop_r;
  reg start_r;
  reg rw_r;
  reg tx_busy_r;
  reg ua_r;
  reg bf_r;
  reg [3:0] bit_cnt_r;
  reg [6:0] shift_r;
  reg first_byte_r;
  reg second_addr_r;
  reg matched_r;

  // ****************************************
  // byte framing
  // ****************************************
  wire run = enable_r;
  wire master_m = is_master(mode_r);
  wire slave_m = is_slave(mode_r);
  wire ten_m = is_ten(mode_r);
  wire data_bit = run & scl_rise & (bit_cnt_r != `I2SF_ACK_BIT);
  wire byte_done = data_bit & (bit_cnt_r == `I2SF_LAST_DATA_BIT);
  wire ack_bit = run & scl_rise & (bit_cnt_r == `I2SF_ACK_BIT);
  wire nack = ack_bit & sda_s;
  wire [7:0] rx_byte = {shift_r, sda_s};
  wire addr_byte = byte_done & slave_m & (first_byte_r | second_addr_r);
  wire hi_match = (rx_byte[7:1] == slv_addr_r[7:1]);
  wire lo_match = (rx_byte == slv_addr_r);
  wire addr_hit = first_byte_r ? hi_match : lo_match;
  wire data_byte = byte_done & ~(first_byte_r | second_addr_r);
  wire slave_rx = data_byte & slave_m & matched_r & ~rw_r;
  wire master_rx = data_byte & master_m & ctl2_r[3];
  wire tx_byte_out = data_byte & ((slave_m & matched_r & rw_r) | (master_m & tx_busy_r));

  wire wr_status = reg_wr & hit(reg_addr, `I2SF_OFS_STATUS);
  wire wr_ctrl = reg_wr & hit(reg_addr, `I2SF_OFS_CTRL);
  wire wr_ctrl2 = reg_wr & hit(reg_addr, `I2SF_OFS_CTRL2);
  wire wr_addr = reg_wr & hit(reg_addr, `I2SF_OFS_SLV_ADDR);
  wire wr_buf = reg_wr & hit(reg_addr, `I2SF_OFS_BUFFER);
  wire wr_mask = reg_wr & hit(reg_addr, `I2SF_OFS_IRQ_MASK);
  wire rd_buf = reg_rd & hit(reg_addr, `I2SF_OFS_BUFFER);
  wire rd_irq = reg_rd & hit(reg_addr, `I2SF_OFS_IRQ_STAT);

  // direction bit: transmit busy in master, captured r/w in slave
  wire rw_view = master_m ? tx_busy_r : (slave_m & rw_r); // [RULE_03] [RULE_07]
  wire da_view = slave_m & data_addr_r; // [RULE_01]
  // bus flags read zero as soon as the port is off, update request only in 10-bit slave
  wire [7:0] status_view = {slew_r, smbus_r, da_view,
                            {5{run}} & {stop_r, start_r, rw_view, ua_r & ten_m, bf_r}}; // [RULE_04]

  // events gathered for the interrupt status
  wire [`I2SF_IRQ_BITS-1:0] ev;
  assign ev[`I2SF_IRQ_BYTE] = byte_done & (slave_rx | master_rx | tx_byte_out);
  assign ev[`I2SF_IRQ_START] = run & start_det;
  assign ev[`I2SF_IRQ_STOP] = run & stop_det;
  assign ev[`I2SF_IRQ_UA] = addr_byte & ten_m & addr_hit;

  reg [`I2SF_IRQ_BITS-1:0] irq_stat_nxt;
  reg [7:0] rdata_nxt;

  // read mux, unmapped offsets read zero
  always @* begin
    rdata_nxt = `I2SF_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `I2SF_OFS_STATUS: rdata_nxt = status_view;
        `I2SF_OFS_CTRL: rdata_nxt = {2'b00, enable_r, 1'b0, mode_r};
        `I2SF_OFS_CTRL2: rdata_nxt = {3'b000, ctl2_r};
        `I2SF_OFS_SLV_ADDR: rdata_nxt = slv_addr_r;
        `I2SF_OFS_BUFFER: rdata_nxt = buffer_r;
        `I2SF_OFS_IRQ_STAT: rdata_nxt = {4'h0, irq_stat_r};
        `I2SF_OFS_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
        default: rdata_nxt = `I2SF_RST_BYTE;
      endcase
    end
  end

  // sticky interrupt bits, read clears, new event wins
  always @* begin
    irq_stat_nxt = rd_irq ? {`I2SF_IRQ_BITS{1'b0}} : irq_stat_r;
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  // ****************************************
  // register port and interrupt
  // ****************************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `I2SF_RST_BYTE;
      irq_r <= 1'b0;
      slew_r <= 1'b0;
      smbus_r <= 1'b0;
      enable_r <= 1'b0;
      mode_r <= 4'h0;
      ctl2_r <= {`I2SF_C2_MASTER_BITS{1'b0}};
      slv_addr_r <= `I2SF_RST_BYTE;
      irq_stat_r <= {`I2SF_IRQ_BITS{1'b0}};
      irq_mask_r <= {`I2SF_IRQ_BITS{1'b0}};
      active_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      if (wr_status) begin
        slew_r <= reg_wdata[`I2SF_ST_SLEW];
        smbus_r <= reg_wdata[`I2SF_ST_SMBUS];
      end
      if (wr_ctrl) begin
        enable_r <= reg_wdata[`I2SF_CT_ENABLE];
        mode_r <= reg_wdata[`I2SF_CT_MODE_HI:`I2SF_CT_MODE_LO];
      end
      if (wr_ctrl2)
        ctl2_r <= reg_wdata[`I2SF_C2_MASTER_BITS-1:0];
      if (wr_addr)
        slv_addr_r <= reg_wdata;
      if (wr_mask)
        irq_mask_r <= reg_wdata[`I2SF_IRQ_BITS-1:0];
      active_r <= enable_r & master_m & (tx_busy_r | (|ctl2_r)); // [RULE_08]
    end
  end

  // ****************************************
  // bus tracking and flags
  // ****************************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_addr_r <= 1'b0;
      stop_r <= 1'b0;
      start_r <= 1'b0;
      rw_r <= 1'b0;
      tx_busy_r <= 1'b0;
      ua_r <= 1'b0;
      bf_r <= 1'b0;
      buffer_r <= `I2SF_RST_BYTE;
      bit_cnt_r <= 4'h0;
      shift_r <= 7'h00;
      first_byte_r <= 1'b0;
      second_addr_r <= 1'b0;
      matched_r <= 1'b0;
    end else if (!run) begin
      // disabled port: bus flags and framing drop
      stop_r <= 1'b0;
      start_r <= 1'b0;
      rw_r <= 1'b0;
      tx_busy_r <= 1'b0;
      ua_r <= 1'b0;
      bf_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      first_byte_r <= 1'b0;
      second_addr_r <= 1'b0;
      matched_r <= 1'b0;
    end else begin
      // software side: address rewrite, buffer access
      if (wr_addr)
        ua_r <= 1'b0; // [RULE_04]
      if (rd_buf)
        bf_r <= 1'b0; // [RULE_05]
      if (wr_buf) begin
        buffer_r <= reg_wdata;
        bf_r <= 1'b1; // [RULE_05]
        if (master_m)
          tx_busy_r <= 1'b1; // [RULE_03]
      end
      // bit framing, ack clock excluded from byte
      if (data_bit) begin
        shift_r <= rx_byte[6:0];
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (ack_bit) begin
        bit_cnt_r <= 4'h0;
        tx_busy_r <= 1'b0; // [RULE_03]
        if (nack)
          rw_r <= 1'b0; // [RULE_07]
      end
      // address phase in slave mode
      if (addr_byte) begin
        data_addr_r <= 1'b0; // [RULE_01]
        first_byte_r <= 1'b0;
        second_addr_r <= 1'b0;
        if (ten_m) begin
          if (addr_hit)
            ua_r <= 1'b1; // [RULE_04]
          if (first_byte_r & hi_match & ~rx_byte[0])
            second_addr_r <= 1'b1;
          if ((first_byte_r & hi_match & rx_byte[0]) | (second_addr_r & lo_match)) begin
            matched_r <= 1'b1;
            rw_r <= first_byte_r & rx_byte[0]; // [RULE_07]
          end
        end else if (hi_match) begin
          matched_r <= 1'b1;
          rw_r <= rx_byte[0]; // [RULE_07]
        end
      end else if (byte_done) begin
        first_byte_r <= 1'b0;
        if (slave_m)
          data_addr_r <= 1'b1; // [RULE_01]
      end
      // received byte lands in buffer at eighth bit
      if (slave_rx | master_rx) begin
        buffer_r <= rx_byte;
        bf_r <= 1'b1; // [RULE_05]
      end else if (tx_byte_out)
        bf_r <= 1'b0; // [RULE_05]
      // bus conditions restart framing
      if (start_det) begin
        start_r <= 1'b1; // [RULE_06]
        stop_r <= 1'b0; // [RULE_02]
        rw_r <= 1'b0; // [RULE_07]
        bit_cnt_r <= 4'h0;
        first_byte_r <= 1'b1;
        second_addr_r <= 1'b0;
        matched_r <= 1'b0;
      end
      if (stop_det) begin
        stop_r <= 1'b1; // [RULE_02]
        start_r <= 1'b0; // [RULE_06]
        rw_r <= 1'b0; // [RULE_07]
        tx_busy_r <= 1'b0;
        bit_cnt_r <= 4'h0;
        first_byte_r <= 1'b0;
        second_addr_r <= 1'b0;
        matched_r <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign master_active = active_r;

endmodule // i2sf_status_top

`default_nettype wire

// File: tb/i2sf_assertions.sv
// port checker of the i2c status block
// assumes it is bound to i2sf_status_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module i2sf_assertions (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic irq,
  input wire logic master_active
);
  // ****************************************
  // control shadow and properties
  // ****************************************
  logic [7:0] ctl_r;
  wire st_rd = reg_rd && reg_addr == 8'h00;
  wire mst = ctl_r[5] && (ctl_r[3:0] == 4'h8 || ctl_r[3:0] == 4'hb);
  wire ten = ctl_r[3:0] == 4'h7 || ctl_r[3:0] == 4'hf;
  // copy of the control register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ctl_r <= 8'h00;
    else if (reg_wr && reg_addr == 8'h01) ctl_r <= reg_wdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_flags_excl: assert property (st_rd |=> !(reg_rdata[4] && reg_rdata[3]))
    else $error("start and stop flags both set");
  a_off_clear: assert property (st_rd && !ctl_r[5] |=> reg_rdata[4:0] == 5'h00)
    else $error("bus flags set while disabled");
  a_master_da: assert property (st_rd && mst |=> !reg_rdata[5])
    else $error("data flag set in master mode");
  a_ua_mode: assert property (st_rd && !ten |=> !reg_rdata[1])
    else $error("address update outside 10-bit slave");
  a_ua_clear: assert property (reg_wr && reg_addr == 8'h03 ##1 st_rd |=> !reg_rdata[1])
    else $error("address update kept after address write");
  a_bf_clear: assert property (reg_rd && reg_addr == 8'h04 ##1 st_rd |=> !reg_rdata[0])
    else $error("buffer full kept after buffer read");
  a_tx_busy: assert property (reg_wr && reg_addr == 8'h04 && mst ##1 st_rd |=> reg_rdata[2])
    else $error("no transmit busy after buffer write");
  a_mact_off: assert property (!ctl_r[5] |=> !master_active)
    else $error("master active while disabled");
  a_mact_on: assert property (reg_wr && reg_addr == 8'h02 && reg_wdata[4:0] != 5'h00 && mst |-> ##[1:2] master_active)
    else $error("master active missing after enable bit");
  c_start: cover property (st_rd ##1 reg_rdata[3]);
  c_irq: cover property ($rose(irq));
  c_mact: cover property ($rose(master_active));
endmodule // i2sf_assertions
bind i2sf_status_top i2sf_assertions chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .sda_in(sda_in), .irq(irq), .master_active(master_active));
`default_nettype wire

// File: tb/i2sf_bus_peer.sv
// behavioural i2c bus peer driving both lines
// assumes pulled-up lines: a released line reads 1
`timescale 1ns/10ps
`default_nettype none
module i2sf_bus_peer (
  output var logic scl,
  output var logic sda
);
  // ****************************************
  // frame tasks, 64 ns bit time
  // ****************************************
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start or repeated start
  task start_c;
    sda = 1'b1;
    #16 scl = 1'b1;
    #16 sda = 1'b0;
    #16 scl = 1'b0;
  endtask
  // stop, clock then stands high
  task stop_c;
    sda = 1'b0;
    #16 scl = 1'b1;
    #16 sda = 1'b1;
    #16;
  endtask
  // eight bits msb first, ack bit, then release
  task tx(input logic [7:0] b, input logic nack);
    for (int i = 0; i < 9; i++) begin
      #16 sda = (i < 8) ? b[7-i] : nack;
      #16 scl = 1'b1;
      #32 scl = 1'b0;
    end
    #16 sda = 1'b1;
  endtask
endmodule // i2sf_bus_peer
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench of the i2c status block
// assumes peer model and bound checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************
  // stimulus, scoreboard and checks
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  wire [7:0] reg_rdata;
  wire scl;
  wire sda;
  wire irq;
  wire master_active;
  logic [15:0] exp_q[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [7:0] sa, d, hb, lb;
  always #2 sys_clk = ~sys_clk;
  i2sf_bus_peer peer_u (.scl(scl), .sda(sda));
  i2sf_status_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda), .irq(irq),
    .master_active(master_active));
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read stroke, note masked expectation
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // let the pin synchroniser settle
  task sy;
    idle;
    repeat (4) @(posedge sys_clk);
  endtask
  // irq and master_active levels between edges
  task ckp(input logic [1:0] e);
    @(negedge sys_clk);
    chk("irq_mact", {6'h00, irq, master_active}, {6'h00, e});
    @(posedge sys_clk);
  endtask
  task print_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data checker, one cycle after each read
  always @(posedge sys_clk) begin : mon
    logic [15:0] e;
    if (rd_d) begin
      e = exp_q.pop_front();
      chk("rdata", reg_rdata & e[15:8], e[7:0]);
    end
    rd_d <= reg_rd;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(32'h078b_fd0e));
    sa = 8'h20 | (8'($urandom_range(63)) << 1);
    d = 8'($urandom);
    hb = 8'hf0 | (8'($urandom_range(3)) << 1);
    lb = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 8'hff, 8'h00);
    rd(8'h07 + 8'($urandom_range(248)), 8'hff, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hff, 8'hc0);
    wr(8'h01, 8'h26);
    wr(8'h03, sa);
    wr(8'h06, 8'h0f);
    idle;
    peer_u.start_c;
    sy;
    ckp(2'b10);
    rd(8'h00, 8'h18, 8'h08);
    rd(8'h05, 8'h02, 8'h02);
    idle;
    ckp(2'b00);
    peer_u.tx(sa, 1'b0);
    sy;
    rd(8'h00, 8'h24, 8'h00);
    peer_u.tx(d, 1'b0);
    sy;
    rd(8'h00, 8'h25, 8'h21);
    rd(8'h04, 8'hff, d);
    rd(8'h00, 8'h01, 8'h00);
    rd(8'h05, 8'h01, 8'h01);
    idle;
    ckp(2'b00);
    peer_u.stop_c;
    sy;
    rd(8'h00, 8'h18, 8'h10);
    peer_u.start_c;
    peer_u.tx(sa | 8'h01, 1'b0);
    sy;
    rd(8'h00, 8'h04, 8'h04);
    peer_u.tx(d, 1'b1);
    sy;
    rd(8'h00, 8'h04, 8'h00);
    peer_u.stop_c;
    sy;
    rd(8'h05, 8'h0f, 8'h07);
    wr(8'h01, 8'h2e);
    wr(8'h06, 8'h00);
    idle;
    peer_u.start_c;
    peer_u.stop_c;
    sy;
    ckp(2'b00);
    rd(8'h05, 8'h06, 8'h06);
    wr(8'h01, 8'h27);
    wr(8'h03, hb);
    idle;
    peer_u.start_c;
    peer_u.tx(hb, 1'b0);
    sy;
    rd(8'h00, 8'h02, 8'h02);
    rd(8'h05, 8'h08, 8'h08);
    wr(8'h03, lb);
    rd(8'h00, 8'h02, 8'h00);
    idle;
    peer_u.tx(lb, 1'b0);
    sy;
    rd(8'h00, 8'h02, 8'h02);
    wr(8'h03, hb);
    rd(8'h00, 8'h02, 8'h00);
    idle;
    peer_u.stop_c;
    sy;
    wr(8'h01, 8'h28);
    wr(8'h04, d);
    rd(8'h00, 8'h24, 8'h04);
    idle;
    ckp(2'b01);
    peer_u.start_c;
    peer_u.tx(d, 1'b0);
    sy;
    rd(8'h00, 8'h04, 8'h00);
    idle;
    ckp(2'b00);
    wr(8'h01, 8'h2b);
    for (int i = 0; i < 5; i++) begin
      wr(8'h02, 8'h01 << i);
      idle;
      ckp(2'b01);
    end
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h00, 8'h1f, 8'h00);
    idle;
    ckp(2'b00);
    repeat (2) @(posedge sys_clk);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
